// ### core_stack_memory_control.sv
// Contract
// - Sixteen-entry, sixteen-bit hardware stack
// - Call, return, interrupt use stack automatically
// - Software push, pop, interrupt-pop supported
// - Any reset sets stack index 0Fh
// - Call/push/vector: increment, then write
// - Return/pop: read, then decrement
// - Utility ROM 4K words at 8000h
// - Every reset fetches from utility ROM
// - 256-word data SRAM, 64K-word flash
// - Harvard default, optional cross-mapping modes
// - Optional unified pseudo-Von Neumann map
// - Password is program words 0010h-001Fh
// - Lock set denies debug until password
// - Lock clear allows debug freely
// - Mass erase leaves password all ones
// - Test port active after reset
// - Loader request in reset runs loader
// - Loader clears request, app starts directly
// - Stop mode halts oscillators and clock
// - Stop exits on interrupt or reset
// - Wake waits warmup or runs on RC
`timescale 1ns/1ps
`default_nettype none
`include "core_stack_memory_control_defs.svh"
module core_stack_memory_control #(
    parameter int WARMUP = 16384
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Core stack port
    input wire logic [2:0] stackOp,
    input wire logic [15:0] stackWriteData,
    output logic [15:0] stackReadData,
    // Test port, flash events and external interrupts
    input wire logic testLoaderRequest,
    input wire logic flashMassErase,
    input wire logic [7:0] extInterrupt,
    // Clock, fetch, debug, test port and map control
    output logic oscEnable,
    output logic rcEnable,
    output logic clockRun,
    output logic [15:0] fetchStart,
    output logic debugGranted,
    output logic testPortActive,
    output logic [2:0] mapMode
);
    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    logic [1:0] loaderSync;
    logic [7:0] intSync1;
    logic [7:0] intSync2;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            loaderSync <= 2'h0;
            intSync1 <= 8'h00;
            intSync2 <= 8'h00;
        end else begin
            loaderSync <= {loaderSync[0], testLoaderRequest};
            intSync1 <= extInterrupt;
            intSync2 <= intSync1;
        end
    end
    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    core_stack_memory_control_pkg::bus_req_type busReq;
    logic busPending;
    wire takeReq = hsel && hready && htrans[1];
    wire [11:0] regAddr = busReq.addr;
    wire doWrite = busPending && busReq.write;
    wire doRead = busPending && !busReq.write;
    wire selOp = regAddr == `REG_STACK_OP;
    wire selData = regAddr == `REG_STACK_DATA;
    wire selCtrl = regAddr == `REG_SYSTEM_CONTROL;
    wire selMap = regAddr == `REG_MAP_XLATE;
    wire selPw = regAddr == `REG_PASSWORD;
    wire selDbg = regAddr == `REG_DEBUG_REQ;
    wire selPwr = regAddr == `REG_POWER;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            busPending <= 1'b0;
            busReq <= '0;
        end else begin
            busPending <= takeReq;
            busReq <= takeReq ? {haddr[11:0], hwrite} : busReq;
        end
    end
    // ----------------------------------------
    // Hardware stack
    // ----------------------------------------
    logic [15:0] stackMem [16];
    logic [3:0] stackIndex;
    logic [15:0] stackOutReg;
    logic [15:0] swData;
    wire [2:0] swOp = (doWrite && selOp) ? hwdata[2:0] : 3'h0;
    wire [2:0] effOp = (stackOp != 3'h0) ? stackOp : swOp;
    wire [15:0] effData = (stackOp != 3'h0) ? stackWriteData : swData;
    wire isPushKind = effOp == core_stack_memory_control_pkg::OP_CALL
        || effOp == core_stack_memory_control_pkg::OP_PUSH
        || effOp == core_stack_memory_control_pkg::OP_VECTOR;
    wire isPopKind = effOp[2];
    wire [3:0] upIndex = stackIndex + 4'h1;
    wire [3:0] downIndex = stackIndex - 4'h1;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            stackIndex <= `STACK_TOP;
            stackOutReg <= 16'h0000;
            swData <= 16'h0000;
        end else begin
            if (doWrite && selData) begin
                swData <= hwdata[15:0];
            end
            if (isPushKind) begin
                stackIndex <= upIndex;
            end else if (isPopKind) begin
                stackOutReg <= stackMem[stackIndex];
                stackIndex <= downIndex;
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (isPushKind) begin
            stackMem[upIndex] <= effData;
        end
    end
    // ----------------------------------------
    // System control and map modes
    // ----------------------------------------
    logic [7:0] sysCtrl;
    logic [15:0] pwMatch;
    logic [15:0] pwExpect [16];
    logic [3:0] pwIndex;
    logic unlocked;
    logic debugReq;
    wire lockFlag = sysCtrl[`SC_LOCK_BIT];
    wire loaderFlag = sysCtrl[`SC_LOADER_BIT];
    wire [15:0] pwNext = pwMatch;
    // Window after reset in which the synchronised loader request is captured
    logic [1:0] bootWindow;
    wire bootOpen = bootWindow != 2'h0;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bootWindow <= `BOOT_WINDOW;
        end else if (bootOpen) begin
            bootWindow <= bootWindow - 2'h1;
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sysCtrl <= `SC_RESET;
        end else if (doWrite && selCtrl) begin
            sysCtrl <= {hwdata[7:1], sysCtrl[`SC_LOADER_BIT] & hwdata[0]};
        end else if (loaderSync[1] && (bootOpen || !clockRun)) begin
            sysCtrl[`SC_LOADER_BIT] <= 1'b1;
        end
    end
    // Password words 0010h..001Fh as mirrored from flash
    always_ff @(posedge core_clk) begin
        if (flashMassErase) begin
            for (int i = 0; i < 16; i++) begin
                pwExpect[i] <= `ERASED_WORD;
            end
        end else if (doWrite && selMap && hwdata[31]) begin
            pwExpect[hwdata[19:16]] <= hwdata[15:0];
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwIndex <= 4'h0;
            unlocked <= 1'b0;
            pwMatch <= 16'hFFFF;
        end else if (doWrite && selPw) begin
            pwMatch[pwIndex] <= pwMatch[pwIndex] && hwdata[15:0] == pwExpect[pwIndex];
            pwIndex <= pwIndex + 4'h1;
            if (pwIndex == 4'hF) begin
                unlocked <= &pwNext[14:0] && hwdata[15:0] == pwExpect[4'hF];
                pwMatch <= 16'hFFFF;
            end
        end
    end
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            debugReq <= 1'b0;
            debugGranted <= 1'b0;
            mapMode <= 3'h0;
            fetchStart <= `UROM_BASE;
            testPortActive <= 1'b1;
        end else begin
            debugReq <= (doWrite && selDbg) ? hwdata[0] : debugReq;
            debugGranted <= debugReq && (!lockFlag || unlocked);
            mapMode <= {sysCtrl[`SC_PVN_BIT], sysCtrl[`SC_UPA_BIT], sysCtrl[`SC_CDA_BIT]};
            fetchStart <= `UROM_BASE;
            testPortActive <= 1'b1;
        end
    end
    // ----------------------------------------
    // Stop mode and warmup
    // ----------------------------------------
    core_stack_memory_control_pkg::power_state_type pwrState;
    logic [15:0] warmCount;
    logic fastWake;
    wire wakeEvent = |(intSync2 & sysCtrl[7:0]);
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pwrState <= core_stack_memory_control_pkg::PWR_RUN;
            warmCount <= 16'h0000;
            fastWake <= 1'b0;
            oscEnable <= 1'b1;
            rcEnable <= 1'b1;
            clockRun <= 1'b1;
        end else begin
            if (doWrite && selPwr) begin
                fastWake <= hwdata[`PWR_FASTWAKE_BIT];
            end
            unique case (pwrState)
                core_stack_memory_control_pkg::PWR_RUN: begin
                    if (doWrite && selPwr && hwdata[`PWR_STOP_BIT]) begin
                        pwrState <= core_stack_memory_control_pkg::PWR_STOP;
                        oscEnable <= 1'b0;
                        rcEnable <= 1'b0;
                        clockRun <= 1'b0;
                    end
                end
                core_stack_memory_control_pkg::PWR_STOP: begin
                    if (wakeEvent || |intSync2) begin
                        pwrState <= core_stack_memory_control_pkg::PWR_WARMUP;
                        oscEnable <= 1'b1;
                        rcEnable <= 1'b1;
                        clockRun <= fastWake;
                        warmCount <= 16'(WARMUP);
                    end
                end
                core_stack_memory_control_pkg::PWR_WARMUP: begin
                    warmCount <= warmCount - 16'h0001;
                    if (warmCount == 16'h0000) begin
                        clockRun <= 1'b1;
                        pwrState <= core_stack_memory_control_pkg::PWR_RUN;
                    end
                end
                default: pwrState <= core_stack_memory_control_pkg::PWR_RUN;
            endcase
        end
    end
    // ----------------------------------------
    // Read mux and outputs
    // ----------------------------------------
    wire [31:0] readMux =
        selData ? {16'h0000, stackOutReg} :
        (regAddr == `REG_STACK_STATUS) ? {28'h0000000, stackIndex} :
        selCtrl ? {24'h000000, sysCtrl} :
        selPwr ? {28'h0000000, fastWake, pwrState, unlocked} :
        (regAddr == `REG_FETCH_START) ? {16'h0000, fetchStart} :
        32'h00000000;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            hrdata <= 32'h00000000;
            stackReadData <= 16'h0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hrdata <= (takeReq && !hwrite) ? 32'h00000000 : (doRead ? readMux : hrdata);
            stackReadData <= isPopKind ? stackMem[stackIndex] : stackReadData;
            hreadyout <= !(takeReq && !hwrite);
            hresp <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### core_stack_memory_control_defs.svh
`ifndef CORE_STACK_MEMORY_CONTROL_DEFS_SVH
`define CORE_STACK_MEMORY_CONTROL_DEFS_SVH
// ----------------------------------------
// Register map (byte offsets)
// ----------------------------------------
`define REG_STACK_OP 12'h000
`define REG_STACK_DATA 12'h004
`define REG_STACK_STATUS 12'h008
`define REG_SYSTEM_CONTROL 12'h00C
`define REG_MAP_XLATE 12'h010
`define REG_PASSWORD 12'h014
`define REG_DEBUG_REQ 12'h018
`define REG_POWER 12'h01C
`define REG_FETCH_START 12'h020
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define STACK_TOP 4'hF
`define UROM_BASE 16'h8000
`define UROM_WORDS 17'h01000
`define USER_START 16'h0000
`define PW_FIRST 16'h0010
`define PW_WORDS 5'h10
`define DATA_WORDS 17'h00100
`define ERASED_WORD 16'hFFFF
`define SC_LOCK_BIT 1
`define SC_CDA_BIT 4
`define SC_UPA_BIT 3
`define SC_PVN_BIT 2
`define SC_LOADER_BIT 0
`define SC_RESET 8'h02
`define PWR_STOP_BIT 0
`define PWR_FASTWAKE_BIT 1
`define WARMUP_CYCLES 16'h4000
`define BOOT_WINDOW 2'h3
`endif

// ### core_stack_memory_control_pkg.sv
package core_stack_memory_control_pkg;
    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_CALL = 3'h1,
        OP_PUSH = 3'h2,
        OP_VECTOR = 3'h3,
        OP_RETURN = 3'h4,
        OP_INTERRUPT_RETURN = 3'h5,
        OP_POP = 3'h6,
        OP_INTERRUPT_POP = 3'h7
    } stack_op_type;
    typedef enum logic [1:0] {
        PWR_RUN = 2'h0,
        PWR_STOP = 2'h1,
        PWR_WARMUP = 2'h2
    } power_state_type;
    typedef struct packed {
        logic [11:0] addr;
        logic write;
    } bus_req_type;
endpackage

// ### loader_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module loader_host_model (
    // Test port
    input wire logic testPortActive,
    output logic testLoaderRequest
);
    initial testLoaderRequest = 1'b0;
    task automatic setRequest(input logic level);
        if (testPortActive === 1'b1 || !level) testLoaderRequest <= level;
    endtask
endmodule
`default_nettype wire

// ### core_stack_memory_control_sva.sv
`timescale 1ns/1ps
`default_nettype none
module core_stack_memory_control_sva (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    // Core side
    input wire logic [2:0] stackOp,
    input wire logic [15:0] stackWriteData,
    input wire logic [15:0] stackReadData,
    input wire logic [7:0] extInterrupt,
    input wire logic oscEnable,
    input wire logic rcEnable,
    input wire logic clockRun,
    input wire logic [15:0] fetchStart,
    input wire logic testPortActive
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire logic taken = hsel && hready && htrans[1];
    wire logic stopped = !clockRun && !oscEnable && !rcEnable;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    sequence s_gapPop;
        (stackOp == 3'h0) ##1 stackOp[2];
    endsequence
    property p_lifo;
        logic [15:0] d;
        (stackOp == 3'h2, d = stackWriteData) ##1 s_gapPop |=> ##1 stackReadData == d;
    endproperty
    a_lifo: assert property (p_lifo) else $error("pop after push mismatch");
    property p_okay; hresp == 1'b0; endproperty
    a_okay: assert property (p_okay) else $error("response not OKAY");
    property p_wready; taken && hwrite |=> hreadyout; endproperty
    a_wready: assert property (p_wready) else $error("write wait state");
    property p_rready; taken && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
    a_rready: assert property (p_rready) else $error("read timing wrong");
    property p_fetch; !$past(reset_n) |-> fetchStart == 16'h8000; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch start not ROM");
    property p_port; testPortActive; endproperty
    a_port: assert property (p_port) else $error("test port idle");
    property p_stop; $fell(clockRun) |-> ##[0:2] stopped; endproperty
    a_stop: assert property (p_stop) else $error("oscillators left running");
    property p_hold;
        stopped && extInterrupt == 8'h00 && $past(extInterrupt) == 8'h00 && $past(extInterrupt, 2) == 8'h00
            |=> stopped;
    endproperty
    a_hold: assert property (p_hold) else $error("woke without cause");
endmodule
bind core_stack_memory_control core_stack_memory_control_sva u_core_stack_memory_control_sva (
    .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .stackOp(stackOp),
    .stackWriteData(stackWriteData), .stackReadData(stackReadData), .extInterrupt(extInterrupt),
    .oscEnable(oscEnable), .rcEnable(rcEnable), .clockRun(clockRun), .fetchStart(fetchStart),
    .testPortActive(testPortActive)
);
`default_nettype wire

// ### core_stack_memory_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module core_stack_memory_control_tb_top;
    logic core_clk, reset_n, hsel, hwrite, hreadyout, hresp, flashMassErase, testLoaderRequest;
    logic oscEnable, rcEnable, clockRun, debugGranted, testPortActive;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, stackOp, mapMode;
    logic [15:0] stackWriteData, stackReadData, fetchStart;
    logic [7:0] extInterrupt;
    int error_cnt = 0, checks_done = 0, cycles = 0, n, nFast;
    wire logic hready = hreadyout;
    core_stack_memory_control #(.WARMUP(4)) u_core_stack_memory_control (
        .core_clk(core_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .stackOp(stackOp), .stackWriteData(stackWriteData),
        .stackReadData(stackReadData), .testLoaderRequest(testLoaderRequest),
        .flashMassErase(flashMassErase), .extInterrupt(extInterrupt), .oscEnable(oscEnable),
        .rcEnable(rcEnable), .clockRun(clockRun), .fetchStart(fetchStart),
        .debugGranted(debugGranted), .testPortActive(testPortActive), .mapMode(mapMode)
    );
    loader_host_model u_loader_host_model (.testPortActive(testPortActive), .testLoaderRequest(testLoaderRequest));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    task automatic summarize;
        if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            check(32'h0, 32'h1, "timeout");
            summarize();
        end
    end
    // ----------------------------------------
    // Bus, stack and scenarios
    // ----------------------------------------
    task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {20'h00000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d); xfer(a, 1'b1, d); endtask
    task automatic resetDut;
        reset_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        reset_n <= 1'b1;
    endtask
    task automatic stackStep(input logic [2:0] op, input logic [15:0] d);
        @(posedge core_clk);
        stackOp <= op;
        stackWriteData <= d;
        @(posedge core_clk);
        stackOp <= 3'h0;
        if (op[2]) begin
            @(posedge core_clk);
            check({16'h0, stackReadData}, {16'h0, d}, "pop");
        end
    endtask
    task automatic testStack;
        xfer(12'h008, 1'b0, 32'h0);
        check(rd & 32'hF, 32'hF, "reset index");
        wr(12'h004, 32'hA5A5);
        wr(12'h000, 32'h2);
        xfer(12'h008, 1'b0, 32'h0);
        check(rd & 32'hF, 32'h0, "wrap index");
        stackStep(3'h6, 16'hA5A5);
        for (int i = 0; i < 16; i++) stackStep(3'h1 + 3'((i + 1) % 3), 16'h1000 + 16'(i));
        xfer(12'h008, 1'b0, 32'h0);
        check(rd & 32'hF, 32'hF, "full index");
        for (int i = 0; i < 16; i++) stackStep(3'h4 + 3'(i % 4), 16'h100F - 16'(i));
    endtask
    task automatic testLock;
        wr(12'h018, 32'h1);
        repeat (2) @(posedge core_clk);
        check({31'h0, debugGranted}, 32'h0, "locked");
        flashMassErase <= 1'b1;
        @(posedge core_clk);
        flashMassErase <= 1'b0;
        repeat (16) wr(12'h014, 32'hFFFF);
        wr(12'h018, 32'h1);
        repeat (2) @(posedge core_clk);
        check({31'h0, debugGranted}, 32'h1, "unlocked");
        resetDut();
        check({29'h0, mapMode}, 32'h0, "harvard");
        wr(12'h00C, 32'h4);
        wr(12'h018, 32'h1);
        repeat (2) @(posedge core_clk);
        check({31'h0, debugGranted}, 32'h1, "open");
        check({31'h0, mapMode[2]}, 32'h1, "unified");
    endtask
    task automatic testLoader;
        u_loader_host_model.setRequest(1'b1);
        resetDut();
        repeat (4) @(posedge core_clk);
        xfer(12'h00C, 1'b0, 32'h0);
        check(rd & 32'h1, 32'h1, "loader set");
        u_loader_host_model.setRequest(1'b0);
        wr(12'h00C, 32'h2);
        xfer(12'h00C, 1'b0, 32'h0);
        check(rd & 32'h3, 32'h2, "loader clear");
    endtask
    task automatic testStop;
        for (int fast = 1; fast >= 0; fast--) begin
            wr(12'h01C, {30'h0, 1'(fast), 1'b1});
            repeat (4) @(posedge core_clk);
            check({29'h0, clockRun, oscEnable, rcEnable}, 32'h0, "stop");
            repeat (10) @(posedge core_clk);
            check({29'h0, clockRun, oscEnable, rcEnable}, 32'h0, "held");
            extInterrupt <= 8'hFF;
            n = 0;
            while (clockRun !== 1'b1 && n < 50) begin
                @(posedge core_clk);
                n++;
            end
            extInterrupt <= 8'h00;
            repeat (10) @(posedge core_clk);
            if (fast == 1) nFast = n;
            else check({31'h0, n > nFast && n >= 4}, 32'h1, "wake");
        end
    endtask
    initial begin
        {reset_n, hsel, hwrite, flashMassErase} = 4'h0;
        {haddr, hwdata} = 64'h0;
        {htrans, stackOp, extInterrupt, stackWriteData} = 29'h0;
        hsize = 3'h2;
        resetDut();
        testStack();
        testLock();
        testLoader();
        testStop();
        summarize();
    end
endmodule
`default_nettype wire
